/* sdl_pkg.sv */
package sdl_pkg;
  localparam int unsigned SDL_WORD_BITS = 16;
  localparam int unsigned SDL_FIFO_DEPTH = 8;
  localparam int unsigned SDL_CORE_CLK_MHZ = 100;
  // Output hold time after a strobe load, in nanoseconds
  localparam int unsigned SDL_HOLD_NS = 5000;
  localparam int unsigned SDL_HOLD_CYCLES = (SDL_HOLD_NS * SDL_CORE_CLK_MHZ) / 1000;
  localparam logic [15:0] SDL_LATCH_RESET = 16'h8000;
  localparam logic [4:0] SDL_COUNT_RESET = 5'h00;
endpackage

/* sdl_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sdl_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } sdl_fifo_state_type;
  sdl_fifo_state_type st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  // Extra pointer bit separates full from empty
  assign empty = (st.wr == st.rd);
  assign full = (st.wr[AW-1:0] == st.rd[AW-1:0]) && (st.wr[AW] != st.rd[AW]);
  assign push = i_in_valid && !full;
  assign pop = !empty && i_out_ready;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[st.rd[AW-1:0]];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wr[AW-1:0]] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

/* sdl_loader.sv */
`timescale 1ns/1ps
`default_nettype none
module sdl_loader
  import sdl_pkg::*;
#(
  parameter int unsigned WORD_BITS = SDL_WORD_BITS,
  parameter int unsigned FIFO_DEPTH = SDL_FIFO_DEPTH,
  parameter int unsigned HOLD_CYCLES = SDL_HOLD_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_serial_clk,
  input wire logic i_serial_data,
  input wire logic i_host_transmit_frame_n,
  input wire logic i_latch_load_strobe_n,
  output logic [15:0] o_latch,
  output logic o_output_hold,
  output logic o_update,
  output logic o_word_valid,
  output logic [15:0] o_word,
  input wire logic i_word_ready
);
  // Frame progress: waiting for frame low, taking bits, word complete until frame high
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SHIFT = 3'b010,
    S_DONE = 3'b100
  } sdl_fsm_type;

  // All registered state in one struct: pin synchroniser pairs and edge history
  // first, then the frame engine, the latch path and the word stream
  typedef struct packed {
    logic [1:0] sclk_sy;
    logic [1:0] sdat_sy;
    logic [1:0] frm_sy;
    logic [1:0] ld_sy;
    logic sclk_d;
    logic ld_d;
    sdl_fsm_type fsm;
    logic auto_mode;
    logic [4:0] count;
    logic [15:0] shift;
    logic [15:0] input_reg;
    logic pending;
    logic [15:0] latch;
    logic [12:0] hold_cnt;
    logic hold;
    logic update;
    logic push;
    logic [15:0] push_data;
    logic out_valid;
    logic [15:0] out_word;
  } sdl_state_type;

  sdl_state_type st, next_st;
  logic fifo_in_ready, fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic fall, ld_fall, frm_n, ld_n, sdat;
  logic [15:0] shifted;
  logic word_done;

  // Count value at which the final bit of a word is taken
  localparam logic [4:0] LAST_BIT = 5'(WORD_BITS - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Decoded edges, read only from second synchroniser stage
  // The serial clock is sampled, never used as a clock: each serial phase must
  // span at least three core cycles or an edge slips through unseen
  assign frm_n = st.frm_sy[1];
  assign ld_n = st.ld_sy[1];
  assign sdat = st.sdat_sy[1];
  assign fall = st.sclk_d && !st.sclk_sy[1];
  assign ld_fall = st.ld_d && !ld_n;
  assign shifted = {st.shift[14:0], sdat}; // MSB first

  // Sixteenth accepted fall of a frame closes the word
  assign word_done = (st.fsm == S_SHIFT) && !frm_n && fall
    && (st.count == LAST_BIT);

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Two-stage synchronisers on every pin from the host
    next_st.sclk_sy = {st.sclk_sy[0], i_serial_clk};
    next_st.sdat_sy = {st.sdat_sy[0], i_serial_data};
    next_st.frm_sy = {st.frm_sy[0], i_host_transmit_frame_n};
    next_st.ld_sy = {st.ld_sy[0], i_latch_load_strobe_n};
    next_st.sclk_d = st.sclk_sy[1];
    next_st.ld_d = ld_n;
    // One-cycle strobes fall back low unless set below
    next_st.update = 1'b0;
    next_st.push = 1'b0;
    case (st.fsm)
      S_IDLE: begin
        // Frame high: edges ignored
        // Mode chosen once per frame; later strobe moves wait for the next frame
        if (!frm_n) begin
          next_st.auto_mode = !ld_n;
          next_st.count = SDL_COUNT_RESET;
          next_st.fsm = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (frm_n) begin
          // Short frame: word dropped, latch kept
          // so a cut frame never disturbs the converter output
          next_st.fsm = S_IDLE;
        end else if (fall) begin
          next_st.shift = shifted;
          next_st.count = st.count + 5'h01;
          if (st.count == LAST_BIT) begin
            next_st.fsm = S_DONE; // Further edges blocked
            next_st.input_reg = shifted;
            next_st.push = 1'b1;
            next_st.push_data = shifted;
            if (st.auto_mode) begin
              next_st.latch = shifted;
              next_st.update = 1'b1;
            end else begin
              next_st.pending = 1'b1;
            end
          end
        end
      end
      S_DONE: begin
        // Falls past the sixteenth arrive here and shift nothing
        if (frm_n) begin
          next_st.fsm = S_IDLE;
        end
      end
      default: begin
        next_st.fsm = S_IDLE;
      end
    endcase
    // Strobe falling edge loads latch when a deferred word waits
    if (ld_fall && st.pending && !next_st.update) begin
      next_st.latch = st.input_reg;
      // A word closing in this same cycle stays pending: the set wins
      next_st.pending = word_done && !st.auto_mode;
      next_st.update = 1'b1;
      next_st.hold = 1'b1;
      next_st.hold_cnt = 13'(HOLD_CYCLES);
    end else if (st.hold) begin
      // Track-and-hold window; no deglitch in automatic mode
      // A second strobe load inside the window reloads the count and
      // stretches it; the host is expected to space its strobes
      if (st.hold_cnt <= 13'h0001) begin
        next_st.hold = 1'b0;
        next_st.hold_cnt = '0;
      end else begin
        next_st.hold_cnt = st.hold_cnt - 13'h0001;
      end
    end
    // Output register of the word stream
    // A word waits here until the consumer takes it
    if (!st.out_valid || i_word_ready) begin
      next_st.out_valid = fifo_out_valid;
      next_st.out_word = fifo_out_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; latch resets to midscale code
  // Clock, frame and strobe histories reset to the idle-high level so no false clock edge follows reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st <= '0;
      st.sclk_sy <= 2'h3;
      st.frm_sy <= 2'h3;
      st.ld_sy <= 2'h3;
      st.sclk_d <= 1'b1;
      st.ld_d <= 1'b1;
      st.fsm <= S_IDLE;
      st.latch <= SDL_LATCH_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Word stream buffer; a full FIFO drops a word, latch path never stalls
  // Dropping beats back-pressure here: the serial link has no way to stall the host
  sdl_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_in_valid(st.push && fifo_in_ready),
    .o_in_ready(fifo_in_ready),
    .i_in_data(st.push_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(!st.out_valid || i_word_ready),
    .o_out_data(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state flip-flops
  assign o_latch = st.latch;
  assign o_output_hold = st.hold;
  assign o_update = st.update;
  assign o_word_valid = st.out_valid;
  assign o_word = st.out_word;
endmodule
`default_nettype wire

/* sdl_loader_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sdl_loader_sva #(
  parameter int unsigned HOLD_CYCLES = 500
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_host_transmit_frame_n,
  input wire logic i_latch_load_strobe_n,
  input wire logic [15:0] o_latch,
  input wire logic o_output_hold,
  input wire logic o_update,
  input wire logic o_word_valid,
  input wire logic [15:0] o_word,
  input wire logic i_word_ready
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  int unsigned hcnt;
  // Run length of the hold flag, so long holds need no big repetition
  always_ff @(posedge i_core_clk) begin
    hcnt <= (i_rst || !o_output_hold) ? 0 : hcnt + 1;
  end
  ////////////////////////////////////////
  sequence s_quiet; (i_host_transmit_frame_n && i_latch_load_strobe_n) [*8]; endsequence
  property p_rst;
    disable iff (1'b0) i_rst |=> o_latch == 16'h8000 && !o_update && !o_output_hold
      && !o_word_valid;
  endproperty
  property p_latch; !$stable(o_latch) |-> o_update; endproperty
  property p_pulse; o_update |=> !o_update; endproperty
  property p_hlen; $fell(o_output_hold) |-> hcnt == HOLD_CYCLES; endproperty
  property p_hmax; hcnt <= HOLD_CYCLES; endproperty
  property p_hcause; $rose(o_output_hold) |-> o_update || $past(o_update); endproperty
  property p_wstall; o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word); endproperty
  property p_quiet; s_quiet |-> !o_update; endproperty
  a_rst: assert property (p_rst) else $error("latch not midscale after reset");
  a_latch: assert property (p_latch) else $error("latch moved without update");
  a_pulse: assert property (p_pulse) else $error("update longer than a cycle");
  a_hlen: assert property (p_hlen) else $error("hold length wrong");
  a_hmax: assert property (p_hmax) else $error("hold overran");
  a_hcause: assert property (p_hcause) else $error("hold without load");
  a_wstall: assert property (p_wstall) else $error("stalled word changed");
  a_quiet: assert property (p_quiet) else $error("update while idle");
endmodule
bind sdl_loader sdl_loader_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (.i_core_clk, .i_rst,
  .i_host_transmit_frame_n, .i_latch_load_strobe_n, .o_latch, .o_output_hold, .o_update,
  .o_word_valid, .o_word, .i_word_ready);
`default_nettype wire

/* sdl_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sdl_host (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_sdata,
  output logic o_frame_n,
  output logic o_strobe_n
);
  // Idle link: clock stands high, frame high
  initial begin
    o_sclk = 1;
    o_sdata = 0;
    o_frame_n = 1;
    o_strobe_n = 0;
  end
  ////////////////////////////////////////
  // Strobe level chosen before a frame picks the update mode
  task automatic mode(input logic s);
    @(posedge i_clk);
    o_strobe_n <= s;
  endtask
  // Four core cycles per serial phase: 80 ns serial clock; MSB first
  // Data moves with the rising serial edge, so it is settled at the fall
  task automatic send(input logic [31:0] v, input int n);
    @(posedge i_clk);
    o_frame_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_sdata <= v[31-i];
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    o_sdata <= ~o_sdata; // Released line shows no stale bit
    repeat (4) @(posedge i_clk);
    o_frame_n <= 1'b1;
  endtask
  // Pulse returns high well before any next frame
  task automatic load();
    repeat (20) @(posedge i_clk);
    o_strobe_n <= 1'b0;
    repeat (40) @(posedge i_clk);
    o_strobe_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* sdl_loader_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sdl_loader_test;
  import sdl_pkg::*;
  // Short hold window keeps the strobe scenario brief
  localparam int unsigned HOLD = 4;
  logic clk, rst, sclk, sdata, frame_n, strobe_n, ready, hold, upd, wvalid;
  logic [15:0] latch, word;
  logic [15:0] q[$];
  int n_fail, n_checks, n_upd, n_hold;
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  sdl_host u_host (.i_clk(clk), .o_sclk(sclk), .o_sdata(sdata), .o_frame_n(frame_n),
    .o_strobe_n(strobe_n));
  sdl_loader #(.HOLD_CYCLES(HOLD)) u_sdl_loader (.i_core_clk(clk), .i_rst(rst),
    .i_serial_clk(sclk), .i_serial_data(sdata), .i_host_transmit_frame_n(frame_n),
    .i_latch_load_strobe_n(strobe_n), .o_latch(latch), .o_output_hold(hold),
    .o_update(upd), .o_word_valid(wvalid), .o_word(word), .i_word_ready(ready));
  // Count pulses and collect accepted words
  always @(posedge clk) begin
    if (upd === 1'b1) n_upd++;
    if (hold === 1'b1) n_hold++;
    if (wvalid === 1'b1 && ready === 1'b1) q.push_back(word);
  end
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [31:0] v, input int n);
    u_host.send(v, n);
    repeat (12) @(posedge clk);
    #1;
  endtask
  task automatic t_auto();
    logic [15:0] c[4] = '{16'h0000, 16'hffff, 16'h8000, 16'ha5c3};
    u_host.mode(0);
    foreach (c[i]) begin
      n_upd = 0;
      xfer({c[i], 16'h0000}, 16);
      check("latch", latch, c[i]);
      check("update", n_upd, 1);
    end
  endtask
  task automatic t_defer();
    u_host.mode(1);
    xfer(32'h1234_0000, 16);
    check("held", latch, 16'ha5c3);
    n_hold = 0;
    u_host.load();
    repeat (12) @(posedge clk);
    #1;
    check("loaded", latch, 16'h1234);
    check("hold", n_hold, HOLD);
  endtask
  task automatic t_fifo();
    @(posedge clk) ready <= 0;
    q.delete();
    for (int i = 0; i < 10; i++) xfer(32'h0100_0000 + (i << 16), 16);
    @(posedge clk) ready <= 1;
    repeat (20) @(posedge clk);
    check("fifo first", q[0], 16'h0100);
    // Output register holds one word beyond the FIFO depth
    check("fifo full", q.size(), SDL_FIFO_DEPTH + 1);
    check("fifo last", q[SDL_FIFO_DEPTH], 16'h0108);
  endtask
  task automatic t_reset();
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    check("reset", latch, 16'h8000);
    check("reset word", wvalid, 0);
  endtask
  task automatic t_extra();
    u_host.mode(0);
    #1;
    n_upd = 0;
    xfer(32'hc3a5_ffff, 20);
    check("extra clocks", latch, 16'hc3a5);
    check("extra update", n_upd, 1);
  endtask
  task automatic t_short();
    n_upd = 0;
    xfer(32'h0f0f_0000, 8);
    check("short frame", latch, 16'hc3a5);
    check("short update", n_upd, 0);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Longest path is about 30 us of traffic
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
  initial begin
    rst = 1;
    ready = 1;
    t_reset();
    t_auto();
    t_defer();
    t_extra();
    t_short();
    t_fifo();
    finish_test();
  end
endmodule
`default_nettype wire
